// *** scpcr_params.svh ***
// Offsets, field positions, reset values and timing counts of the pre-driver control bank
`ifndef SCPCR_PARAMS_SVH
`define SCPCR_PARAMS_SVH

// Clock and time base
`define SCPCR_CLK_PERIOD_NS 4
`define SCPCR_NS_PER_US 1000
`define SCPCR_US_PER_MS 1000
`define SCPCR_TICK_CYCLES (`SCPCR_NS_PER_US / `SCPCR_CLK_PERIOD_NS)

// Write word decode
`define SCPCR_CFG_FLAG_BIT 15
`define SCPCR_ADDR_HI 14
`define SCPCR_ADDR_LO 12
`define SCPCR_CMD_GATE 4'h1
`define SCPCR_CMD_MASK 4'h5
`define SCPCR_OLM_BIT 6
`define SCPCR_NUM_CH 6

// Channel config fields
`define SCPCR_RT_HI 11
`define SCPCR_RT_LO 10
`define SCPCR_NPD_BIT 8
`define SCPCR_TOF_HI 7
`define SCPCR_TOF_LO 6
`define SCPCR_TON_HI 5
`define SCPCR_TON_LO 4
`define SCPCR_SB_HI 3
`define SCPCR_SB_LO 1
`define SCPCR_SG_BIT 0
`define SCPCR_CFG_WMASK 12'hD_FF

// Reset values
`define SCPCR_CFG_RESET 12'h000
`define SCPCR_SEL_RESET 6'h00
`define SCPCR_MASK_RESET 7'h00

// Blank and retry times, in microseconds or milliseconds as named
`define SCPCR_ON_BLANK0_US 5
`define SCPCR_ON_BLANK1_US 14
`define SCPCR_ON_BLANK2_US 28
`define SCPCR_ON_BLANK3_US 56
`define SCPCR_OFF_BLANK0_US 80
`define SCPCR_OFF_BLANK1_US 140
`define SCPCR_OFF_BLANK2_US 280
`define SCPCR_OFF_BLANK3_MS 4
`define SCPCR_RETRY_SHORT_MS 10
`define SCPCR_RETRY_LONG_MS 55

`endif

// *** scpcr_pkg.sv ***
// Types of the pre-driver control bank
`default_nettype none
package scpcr_pkg;
  typedef enum logic [1:0] {
    SCPCR_RUN,
    SCPCR_RETRY,
    SCPCR_LOCK
  } scpcr_ch_state_t;
endpackage : scpcr_pkg
`default_nettype wire

// *** scpcr_ctrl_regs.sv ***
// Control, mask, channel config and fault status logic of a six-channel pre-driver
// Function
// - Gate high: select bit, reset high, no fault
// - Masked channel ignores and reports no faults
// - Global mask plus pulldown-off disables open-load check
// - Summary flag set while any fault latched
// - Undervoltage latched until next read
// - Logic reset flag held until next read
// - Overtemperature latched until next read
// - Word id bit: 0 first, 1 second
// - Three latched fault bits per channel
// - Config address picks channel 0-5, 6-7 none
// - Retry field: lockout, short or long retry
// - Pulldown-disable bit turns pulldown current off
// - Turn-off blank: 80/140/280 us, 4 ms
// - Turn-on blank: 5/14/28/56 us
// - Battery short threshold code, 6-18%, 31%
// - Ground short threshold bit, 45% or 66%
// - Config bits reset to zero
// - Config write: top bit 1, then address
// - First word after reset/poll first, then alternate
// - First word channels 0-2, second 3-5
`include "scpcr_params.svh"
`default_nettype none
module scpcr_ctrl_regs #(
  parameter int TICK_DIV = `SCPCR_TICK_CYCLES
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Reset input pin
  input wire logic reset_in_low_n_i,
  // Serial word port
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_word_i,
  input wire logic poll_i,
  output logic [15:0] status_word_o,
  output logic status_valid_o,
  // Diagnostic comparators
  input wire logic [5:0] ground_short_det_i,
  input wire logic [5:0] battery_short_det_i,
  input wire logic [5:0] open_load_det_i,
  input wire logic supply_low_det_i,
  input wire logic overheat_det_i,
  // Drive and analog settings
  output logic [5:0] gate_drive_out_o,
  output logic [5:0] pulldown_disable_o,
  output logic [17:0] battery_short_threshold_o,
  output logic [5:0] ground_short_threshold_o
);

  function automatic logic [11:0] blank_ticks(input logic on, input logic [1:0] ton, input logic [1:0] tof);
    logic [11:0] t;
    t = 12'h000;
    if (on) begin
      unique case (ton)
        2'b00: t = 12'(`SCPCR_ON_BLANK0_US);
        2'b01: t = 12'(`SCPCR_ON_BLANK1_US);
        2'b10: t = 12'(`SCPCR_ON_BLANK2_US);
        2'b11: t = 12'(`SCPCR_ON_BLANK3_US);
      endcase
    end else begin
      unique case (tof)
        2'b00: t = 12'(`SCPCR_OFF_BLANK0_US);
        2'b01: t = 12'(`SCPCR_OFF_BLANK1_US);
        2'b10: t = 12'(`SCPCR_OFF_BLANK2_US);
        2'b11: t = 12'(`SCPCR_OFF_BLANK3_MS * `SCPCR_US_PER_MS);
      endcase
    end
    return t;
  endfunction : blank_ticks

  function automatic logic [15:0] retry_ticks(input logic long_sel);
    return long_sel ? 16'(`SCPCR_RETRY_LONG_MS * `SCPCR_US_PER_MS)
                    : 16'(`SCPCR_RETRY_SHORT_MS * `SCPCR_US_PER_MS);
  endfunction : retry_ticks

  // Pin synchronisers
  logic [20:0] sync1_r;
  logic [20:0] sync2_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= 21'h10_0000;
      sync2_r <= 21'h10_0000;
    end else begin
      sync1_r <= {reset_in_low_n_i, overheat_det_i, supply_low_det_i,
                  open_load_det_i, battery_short_det_i, ground_short_det_i};
      sync2_r <= sync1_r;
    end
  end
  wire logic [5:0] sg_s = sync2_r[5:0];
  wire logic [5:0] sb_s = sync2_r[11:6];
  wire logic [5:0] ol_s = sync2_r[17:12];
  wire logic uv_s = sync2_r[18];
  wire logic ot_s = sync2_r[19];
  wire logic pin_low = !sync2_r[20];

  // Microsecond tick
  logic [15:0] div_r;
  wire logic tick = (div_r == 16'(TICK_DIV - 1));
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) div_r <= 16'h0000;
    else div_r <= tick ? 16'h0000 : div_r + 16'h0001;
  end

  // Write decode
  wire logic is_cfg = wr_valid_i && wr_word_i[`SCPCR_CFG_FLAG_BIT];
  wire logic [2:0] cfg_addr = wr_word_i[`SCPCR_ADDR_HI:`SCPCR_ADDR_LO];
  wire logic wr_gate = wr_valid_i && wr_word_i[15:12] == `SCPCR_CMD_GATE;
  wire logic wr_mask = wr_valid_i && wr_word_i[15:12] == `SCPCR_CMD_MASK;

  // Registers
  logic [5:0] sel_r;
  logic [6:0] mask_r;
  logic [11:0] cfg_r [6];
  logic ptr_r;
  logic lr_r;
  logic uv_r;
  logic ot_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_r <= `SCPCR_SEL_RESET;
      mask_r <= `SCPCR_MASK_RESET;
    end else if (pin_low) begin
      sel_r <= `SCPCR_SEL_RESET;
      mask_r <= `SCPCR_MASK_RESET;
    end else begin
      if (wr_gate) sel_r <= wr_word_i[5:0];
      if (wr_mask) mask_r <= wr_word_i[6:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_r <= 1'b0;
      lr_r <= 1'b1;
      uv_r <= 1'b0;
      ot_r <= 1'b0;
    end else if (pin_low) begin
      ptr_r <= 1'b0;
      lr_r <= 1'b1;
      uv_r <= 1'b0;
      ot_r <= 1'b0;
    end else begin
      if (poll_i) ptr_r <= 1'b0;
      else if (wr_valid_i) ptr_r <= !ptr_r;
      if (wr_valid_i) lr_r <= 1'b0;
      uv_r <= uv_s || (uv_r && !wr_valid_i);
      ot_r <= ot_s || (ot_r && !wr_valid_i);
    end
  end

  // Per-channel fault handling
  logic [17:0] flags;
  logic [5:0] gate_r;
  for (genvar ch = 0; ch < `SCPCR_NUM_CH; ch++) begin : g_ch
    wire logic [11:0] cfg = cfg_r[ch];
    wire logic masked = mask_r[ch];
    wire logic ol_en = !(mask_r[`SCPCR_OLM_BIT] && cfg[`SCPCR_NPD_BIT]);
    logic [11:0] blank_r;
    logic [15:0] retry_r;
    scpcr_pkg::scpcr_ch_state_t st_r;
    logic [2:0] flag_r;
    logic [2:0] gone_r;
    wire logic check = (blank_r == 12'h000);
    wire logic on_chk = check && gate_r[ch];
    wire logic off_chk = check && !gate_r[ch];
    wire logic sg_hit = off_chk && sg_s[ch] && !masked;
    wire logic sb_hit = on_chk && sb_s[ch] && !masked;
    wire logic ol_hit = off_chk && ol_s[ch] && ol_en && !masked;
    wire logic [2:0] hit = {sg_hit, sb_hit, ol_hit};
    wire logic hit_any = |hit;
    wire logic gate_nxt = sel_r[ch] && !pin_low && st_r == scpcr_pkg::SCPCR_RUN && !hit_any;
    wire logic clr_read = wr_valid_i && (ptr_r == (ch >= 3));
    wire logic [2:0] gone_nxt = {off_chk ? !sg_hit : gone_r[2] && !sg_hit,
                                 on_chk ? !sb_hit : gone_r[1] && !sb_hit,
                                 off_chk ? !ol_hit : gone_r[0] && !ol_hit};
    wire logic is_me = is_cfg && cfg_addr == 3'(ch);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) cfg_r[ch] <= `SCPCR_CFG_RESET;
      else if (pin_low) cfg_r[ch] <= `SCPCR_CFG_RESET;
      else if (is_me) cfg_r[ch] <= wr_word_i[11:0] & `SCPCR_CFG_WMASK;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        gate_r[ch] <= 1'b0;
        blank_r <= 12'h000;
      end else begin
        gate_r[ch] <= gate_nxt;
        if (gate_nxt != gate_r[ch])
          blank_r <= blank_ticks(gate_nxt, cfg[`SCPCR_TON_HI:`SCPCR_TON_LO],
                                 cfg[`SCPCR_TOF_HI:`SCPCR_TOF_LO]);
        else if (tick && !check) blank_r <= blank_r - 12'h001;
      end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        flag_r <= 3'b000;
        gone_r <= 3'b000;
      end else if (pin_low) begin
        flag_r <= 3'b000;
        gone_r <= 3'b000;
      end else begin
        flag_r <= (flag_r & ~({3{clr_read}} & gone_r)) | hit;
        gone_r <= gone_nxt;
      end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        st_r <= scpcr_pkg::SCPCR_RUN;
        retry_r <= 16'h0000;
      end else if (pin_low) begin
        st_r <= scpcr_pkg::SCPCR_RUN;
        retry_r <= 16'h0000;
      end else begin
        unique case (st_r)
          scpcr_pkg::SCPCR_RUN: begin
            if (hit_any && cfg[`SCPCR_RT_HI]) begin
              st_r <= scpcr_pkg::SCPCR_RETRY;
              retry_r <= retry_ticks(cfg[`SCPCR_RT_LO]);
            end else if (hit_any) begin
              st_r <= scpcr_pkg::SCPCR_LOCK;
            end
          end
          scpcr_pkg::SCPCR_RETRY: begin
            if (retry_r == 16'h0000) st_r <= scpcr_pkg::SCPCR_RUN;
            else if (tick) retry_r <= retry_r - 16'h0001;
          end
          scpcr_pkg::SCPCR_LOCK: st_r <= scpcr_pkg::SCPCR_LOCK;
          default: st_r <= scpcr_pkg::SCPCR_RUN;
        endcase
      end
    end

    assign flags[ch*3 +: 3] = masked ? 3'b000 : flag_r;
  end

  // Status word
  wire logic any_fault_flag = uv_r || lr_r || ot_r || (|flags);
  wire logic [8:0] chan_bits = ptr_r ? flags[17:9] : flags[8:0];
  wire logic [15:0] word_nxt = {any_fault_flag, uv_r, lr_r, ot_r, ptr_r, 2'b00, chan_bits};

  logic [15:0] status_word_r;
  logic status_valid_r;
  logic [17:0] thr_sb_r;
  logic [5:0] thr_sg_r;
  logic [5:0] npd_r;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_word_r <= 16'h0000;
      status_valid_r <= 1'b0;
    end else begin
      status_valid_r <= wr_valid_i;
      if (wr_valid_i) status_word_r <= word_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < `SCPCR_NUM_CH; i++) begin
      thr_sb_r[i*3 +: 3] = cfg_r[i][`SCPCR_SB_HI:`SCPCR_SB_LO];
      thr_sg_r[i] = cfg_r[i][`SCPCR_SG_BIT];
      npd_r[i] = cfg_r[i][`SCPCR_NPD_BIT];
    end
  end

  assign status_word_o = status_word_r;
  assign status_valid_o = status_valid_r;
  assign gate_drive_out_o = gate_r;
  assign pulldown_disable_o = npd_r;
  assign battery_short_threshold_o = thr_sb_r;
  assign ground_short_threshold_o = thr_sg_r;

endmodule : scpcr_ctrl_regs
`default_nettype wire

// *** scpcr_ctrl_regs_asserts.sv ***
// Port checker for the pre-driver control bank
`default_nettype none
module scpcr_ctrl_regs_asserts (
  // Clock and resets
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic reset_in_low_n_i,
  // Serial word port
  input wire logic wr_valid_i,
  input wire logic poll_i,
  input wire logic [15:0] status_word_o,
  input wire logic status_valid_o,
  // Drive and settings
  input wire logic [5:0] gate_drive_out_o,
  input wire logic [5:0] pulldown_disable_o,
  input wire logic [17:0] battery_short_threshold_o,
  input wire logic [5:0] ground_short_threshold_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  answer_pulse_a: assert property (status_valid_o == $past(wr_valid_i)) else $error("bad answer");
  word_hold_a: assert property (!status_valid_o |-> $stable(status_word_o)) else $error("word moved");
  id_toggle_a: assert property ((wr_valid_i && !poll_i) ##1 (!wr_valid_i && !poll_i)[*2] ##1
    (wr_valid_i && !poll_i) |=> status_word_o[11] != $past(status_word_o[11])) else $error("id");
  poll_first_a: assert property (poll_i ##1 !wr_valid_i ##1 (wr_valid_i && !poll_i)
    |=> !status_word_o[11]) else $error("poll id");
  summary_flag_a: assert property (status_valid_o && (|status_word_o[14:12] || |status_word_o[8:0])
    |-> status_word_o[15]) else $error("summary");
  reset_flag_a: assert property (reset_in_low_n_i[*3] ##1 (wr_valid_i && reset_in_low_n_i)
    ##1 reset_in_low_n_i[*2] ##1 (wr_valid_i && reset_in_low_n_i) |=> !status_word_o[13]) else $error("lr");
  pin_gate_a: assert property (!reset_in_low_n_i[*4] |-> gate_drive_out_o == 6'h00) else $error("gate");
  pin_config_a: assert property (!reset_in_low_n_i[*4] |=> {pulldown_disable_o,
    battery_short_threshold_o, ground_short_threshold_o} == 30'h0000_0000) else $error("config");
endmodule : scpcr_ctrl_regs_asserts
bind scpcr_ctrl_regs scpcr_ctrl_regs_asserts u_chk (.clk_i, .reset_n_i, .reset_in_low_n_i, .wr_valid_i,
  .poll_i, .status_word_o, .status_valid_o, .gate_drive_out_o, .pulldown_disable_o,
  .battery_short_threshold_o, .ground_short_threshold_o);
`default_nettype wire

// *** scpcr_host_model.sv ***
// Host model that sends serial words and keeps the answers
`default_nettype none
module scpcr_host_model (
  // Clock
  input wire logic clk_i,
  // Serial word port
  output logic wr_valid_o,
  output logic [15:0] wr_word_o,
  output logic poll_o,
  input wire logic [15:0] status_word_i,
  input wire logic status_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ans;
  initial begin
    wr_valid_o = 1'b0;
    wr_word_o = 16'h0000;
    poll_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (status_valid_i) ans <= status_word_i;
  end
  task automatic send(input logic [15:0] w);
    @(posedge clk_i);
    wr_valid_o <= 1'b1;
    wr_word_o <= w;
    @(posedge clk_i);
    wr_valid_o <= 1'b0;
    wr_word_o <= ~w;
    @(posedge clk_i);
    #1;
  endtask : send
  task automatic cfg(input logic [14:0] f);
    send({1'b1, f});
  endtask : cfg
  task automatic poll();
    @(posedge clk_i);
    poll_o <= 1'b1;
    @(posedge clk_i);
    poll_o <= 1'b0;
  endtask : poll
endmodule : scpcr_host_model
`default_nettype wire

// *** test_scpcr_ctrl_regs.sv ***
// Self-checking bench of the pre-driver control bank
`default_nettype none
module test_scpcr_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pin_n = 1'b1;
  logic [5:0] gsd = 6'h00, bsd = 6'h00, old = 6'h00;
  logic low_v = 1'b0, hot = 1'b0, wv, pl, sv;
  logic [15:0] wd, sw;
  logic [5:0] gate, pd, sg, epd, esg;
  logic [17:0] sb, esb;
  logic [14:0] r;
  logic [31:0] seed = 32'h2f5f_8564;
  int bad_count = 0, tests_run = 0, cyc = 0;
  scpcr_ctrl_regs #(.TICK_DIV(1)) dut (.clk_i, .reset_n_i, .reset_in_low_n_i(pin_n), .wr_valid_i(wv),
    .wr_word_i(wd), .poll_i(pl), .status_word_o(sw), .status_valid_o(sv), .ground_short_det_i(gsd),
    .battery_short_det_i(bsd), .open_load_det_i(old), .supply_low_det_i(low_v), .overheat_det_i(hot),
    .gate_drive_out_o(gate), .pulldown_disable_o(pd), .battery_short_threshold_o(sb),
    .ground_short_threshold_o(sg));
  scpcr_host_model host (.clk_i, .wr_valid_o(wv), .wr_word_o(wd), .poll_o(pl), .status_word_i(sw),
    .status_valid_i(sv));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [63:0] e, input logic [63:0] s, input string nm);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : w
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    w(1);
    chk(0, {pd, sb, sg, gate}, "reset");
    host.send(16'h1001);
    chk(16'hA000, host.ans, "first word");
    epd = '0;
    esb = '0;
    esg = '0;
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      r = seed[14:0] | ((i == 0) ? 15'h7000 : 15'h0000);
      host.cfg(r);
      if (r[14:12] < 3'd6) begin
        epd[r[14:12]] = r[8];
        esg[r[14:12]] = r[0];
        esb[int'(r[14:12]) * 3 +: 3] = r[3:1];
      end
      chk(i[0] == 1'b0, host.ans[11], "id");
      chk(0, host.ans[13], "lr");
      chk({epd, esb, esg}, {pd, sb, sg}, "config");
    end
    chk(6'h01, gate, "gate on");
    host.cfg(15'h0000);
    host.cfg(15'h1000);
    host.send(16'h5002);
    host.send(16'h1003);
    w(10);
    @(posedge clk_i);
    bsd <= 6'h03;
    low_v <= 1'b1;
    hot <= 1'b1;
    w(8);
    chk(6'h02, gate, "fault gate");
    @(posedge clk_i);
    bsd <= 6'h00;
    w(8);
    chk(6'h02, gate, "lockout");
    host.poll();
    host.send(16'h1003);
    chk(16'hD002, host.ans, "fault word");
    @(posedge clk_i);
    pin_n <= 1'b0;
    low_v <= 1'b0;
    hot <= 1'b0;
    w(6);
    chk(0, {gate, pd, sb, sg}, "pin reset");
    @(posedge clk_i);
    pin_n <= 1'b1;
    w(4);
    host.send(16'h1001);
    chk(1, host.ans[13], "pin lr");
    w(10);
    chk(6'h01, gate, "unlocked");
    @(posedge clk_i);
    gsd <= 6'h04;
    old <= 6'h04;
    w(4);
    host.send(16'h1001);
    host.send(16'h1001);
    chk(16'h8140, host.ans, "off faults");
    print_verdict();
  end
endmodule : test_scpcr_ctrl_regs
`default_nettype wire
